/* File: design/ipcr_regs.sv */
`timescale 1ns/10ps
// ****************************************************************************
// Pipeline control register bank: stage enables, frame latch and event
// selection, windowing, subsampling, format overrides, offsets, line
// interrupt height, test pattern controls and a debug area.
// ****************************************************************************

// Contract
// - First enable byte gates eight colour stages.
// - Second enable byte gates eight exposure stages.
// - Third enable byte gates seven stages, debug.
// - Latch parameters at pre-start or vsync.
// - Three-bit end-of-frame source select.
// - Auto-window bit chooses manual or automatic window.
// - Low three bits give dummy lines.
// - Subsampling mode and vertical subsampling enable.
// - Luma and chroma subsample by combine or drop.
// - Drop mode picks output row and column.
// - Non-drop mode outputs sum or average.
// - Lens centre from registers or window.
// - Format override holds manual modes with enables.
// - Pipeline window offsets, eleven and ten bits.
// - Fuse correction offsets, eleven and ten bits.
// - Line interrupt height, ten bits, resets two.
// - First test pattern register fields.
// - Second test pattern register fields.
// - Four debug reads, one processor debug byte.
module ipcr_regs
(
  // Clock and reset.
  input  wire logic                    mclk_i,
  input  wire logic                    rst_n_i,
  // Byte register access from the serial control bus decoder.
  input  wire logic [15:0]             reg_addr_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  input  wire logic [7:0]              reg_wdata_i,
  output logic      [7:0]              reg_rdata_o,
  output logic                         reg_rvalid_o,
  output logic                         reg_hit_o,
  // Frame timing from the sensor timing logic.
  input  wire logic                    pre_sof_i,
  input  wire logic                    vsync_i,
  // Stage completion events and debug state from the pipeline.
  input  wire ipcr_pkg::ipcr_done_type  done_i,
  input  wire logic [31:0]             isp_debug_i,
  // Controls to the pipeline.
  output ipcr_pkg::ipcr_ctrl_type      ctrl_o,
  output logic                         latch_on_vsync_o,
  output logic      [2:0]              eof_sel_o,
  output logic                         eof_o,
  output logic                         frame_latch_o,
  output logic      [7:0]              cpu_debug_o
);

  // **************************************************************************
  // Storage.
  // **************************************************************************
  logic [7:0]                    reg_q [0:ipcr_pkg::REG_NUM-1];
  logic [ipcr_pkg::REG_NUM-1:0]  wr_sel;
  ipcr_pkg::ipcr_ctrl_type       live;
  ipcr_pkg::ipcr_ctrl_type       ctrl_r;
  logic                          vsync_d_r;
  logic                          vsync_rise;
  logic                          latch_pulse;
  logic                          frame_latch_r;
  logic [7:0]                    rdata_nxt;
  logic                          hit_nxt;
  logic [7:0]                    rdata_r;
  logic                          rvalid_r;

  // Each location decodes its own address; writes to other addresses vanish.
  genvar gi;
  generate
    for (gi = 0; gi < ipcr_pkg::REG_NUM; gi++)
    begin : g_reg
      assign wr_sel[gi] = reg_wr_i && (reg_addr_i == ipcr_pkg::REG_ADDR[gi]);

      ipcr_byte_reg
      #(
        .RST_VAL (ipcr_pkg::REG_RESET[gi]),
        .MASK    (ipcr_pkg::REG_MASK[gi])
      )
      u_byte
      (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .wr_i    (wr_sel[gi]),
        .wdata_i (reg_wdata_i),
        .q_o     (reg_q[gi])
      );
    end
  endgenerate

  // **************************************************************************
  // Field decode of the live register contents.
  // **************************************************************************

  // Stage enables, colour side: bit 7 matrix down to bit 0 lens shading.
  assign live.stage_en_a = reg_q[ipcr_pkg::IDX_EN_A];

  // Stage enables, exposure side: bit 6 is the mono mode, off after reset.
  assign live.stage_en_b = reg_q[ipcr_pkg::IDX_EN_B];

  // Stage enables, fuse and gain side; bit 0 is a debug hook only.
  assign live.stage_en_c = reg_q[ipcr_pkg::IDX_EN_C];

  // Event register: chroma reduction behaviour.
  assign live.chroma_reduce_drop = reg_q[ipcr_pkg::IDX_EVENT][4];

  // Window register: automatic window and dummy line count.
  assign live.auto_window = reg_q[ipcr_pkg::IDX_WINDOW][4];
  assign live.dummy_lines = reg_q[ipcr_pkg::IDX_WINDOW][2:0];

  // Subsampling register, one field per behaviour.
  assign live.vsub_en          = reg_q[ipcr_pkg::IDX_SUBSAMP][7];
  assign live.lenc_centre_auto = reg_q[ipcr_pkg::IDX_SUBSAMP][6];
  assign live.drop_row_second  = reg_q[ipcr_pkg::IDX_SUBSAMP][5];
  assign live.drop_col_second  = reg_q[ipcr_pkg::IDX_SUBSAMP][4];
  assign live.sub_average      = reg_q[ipcr_pkg::IDX_SUBSAMP][3];
  assign live.luma_drop        = reg_q[ipcr_pkg::IDX_SUBSAMP][2];
  assign live.chroma_drop      = reg_q[ipcr_pkg::IDX_SUBSAMP][1];
  assign live.sub_en           = reg_q[ipcr_pkg::IDX_SUBSAMP][0];

  // Output format overrides, each mode paired with its own enable.
  assign live.raw_mode_man    = reg_q[ipcr_pkg::IDX_FORMAT][7:6];
  assign live.yuv_mode_man    = reg_q[ipcr_pkg::IDX_FORMAT][5:4];
  assign live.raw_mode_man_en = reg_q[ipcr_pkg::IDX_FORMAT][3];
  assign live.yuv_mode_man_en = reg_q[ipcr_pkg::IDX_FORMAT][2];
  assign live.yuv_en_man      = reg_q[ipcr_pkg::IDX_FORMAT][1];
  assign live.yuv_en_man_en   = reg_q[ipcr_pkg::IDX_FORMAT][0];

  // Pipeline window offsets joined from their high and low bytes.
  assign live.pipe_hoff = {reg_q[ipcr_pkg::IDX_PHOFF_HI][2:0],
                           reg_q[ipcr_pkg::IDX_PHOFF_LO]};
  assign live.pipe_voff = {reg_q[ipcr_pkg::IDX_PVOFF_HI][1:0],
                           reg_q[ipcr_pkg::IDX_PVOFF_LO]};

  // Fuse memory correction offsets, same layout as the pipeline ones.
  assign live.fuse_hoff = {reg_q[ipcr_pkg::IDX_FHOFF_HI][2:0],
                           reg_q[ipcr_pkg::IDX_FHOFF_LO]};
  assign live.fuse_voff = {reg_q[ipcr_pkg::IDX_FVOFF_HI][1:0],
                           reg_q[ipcr_pkg::IDX_FVOFF_LO]};

  // Line interrupt height.
  assign live.line_irq_vsize = {reg_q[ipcr_pkg::IDX_LIRQ_HI][1:0],
                                reg_q[ipcr_pkg::IDX_LIRQ_LO]};

  // Test pattern generator, first register.
  assign live.pattern_en      = reg_q[ipcr_pkg::IDX_PAT_A][7];
  assign live.bar_style       = reg_q[ipcr_pkg::IDX_PAT_A][5:4];
  assign live.pattern_rolling = reg_q[ipcr_pkg::IDX_PAT_A][2];
  assign live.pipe_test_sel   = reg_q[ipcr_pkg::IDX_PAT_A][1];
  assign live.same_random     = reg_q[ipcr_pkg::IDX_PAT_A][0];

  // Test pattern generator, second register.
  assign live.pattern_seed        = reg_q[ipcr_pkg::IDX_PAT_B][7:4];
  assign live.pattern_square_mono = reg_q[ipcr_pkg::IDX_PAT_B][3];
  assign live.pattern_transparent = reg_q[ipcr_pkg::IDX_PAT_B][2];
  assign live.pattern_sel         = reg_q[ipcr_pkg::IDX_PAT_B][1:0];

  // **************************************************************************
  // Frame parameter latch.
  // **************************************************************************

  // Latch point and event select act at once; they choose the frame timing
  // itself and so cannot wait for a frame boundary.
  assign latch_on_vsync_o = reg_q[ipcr_pkg::IDX_EVENT][3];
  assign eof_sel_o        = reg_q[ipcr_pkg::IDX_EVENT][2:0];

  // The vsync level comes from the sensor timing logic on this clock.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      vsync_d_r <= 1'b0;
    else
      vsync_d_r <= vsync_i;
  end

  assign vsync_rise  = vsync_i & ~vsync_d_r;
  assign latch_pulse = latch_on_vsync_o ? vsync_rise : pre_sof_i;

  // Pipeline settings only change at the chosen frame point, so a frame is processed with one set of values;
  // a multi-byte update arrives whole only if all its bytes are written between two latch points.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_r.stage_en_a          <= ipcr_pkg::REG_RESET[ipcr_pkg::IDX_EN_A];
      ctrl_r.stage_en_b          <= ipcr_pkg::REG_RESET[ipcr_pkg::IDX_EN_B];
      ctrl_r.stage_en_c          <= ipcr_pkg::REG_RESET[ipcr_pkg::IDX_EN_C];
      ctrl_r.chroma_reduce_drop  <= 1'b0;
      ctrl_r.auto_window         <= ipcr_pkg::REG_RESET[ipcr_pkg::IDX_WINDOW][4];
      ctrl_r.dummy_lines         <= ipcr_pkg::REG_RESET[ipcr_pkg::IDX_WINDOW][2:0];
      ctrl_r.vsub_en             <= 1'b0;
      ctrl_r.lenc_centre_auto    <= 1'b0;
      ctrl_r.drop_row_second     <= 1'b0;
      ctrl_r.drop_col_second     <= 1'b0;
      ctrl_r.sub_average         <= ipcr_pkg::REG_RESET[ipcr_pkg::IDX_SUBSAMP][3];
      ctrl_r.luma_drop           <= 1'b0;
      ctrl_r.chroma_drop         <= 1'b0;
      ctrl_r.sub_en              <= 1'b0;
      ctrl_r.raw_mode_man        <= 2'h0;
      ctrl_r.yuv_mode_man        <= 2'h0;
      ctrl_r.raw_mode_man_en     <= 1'b0;
      ctrl_r.yuv_mode_man_en     <= 1'b0;
      ctrl_r.yuv_en_man          <= 1'b0;
      ctrl_r.yuv_en_man_en       <= 1'b0;
      ctrl_r.pipe_hoff           <= 11'h000;
      ctrl_r.pipe_voff           <= 10'h000;
      ctrl_r.fuse_hoff           <= 11'h000;
      ctrl_r.fuse_voff           <= 10'h000;
      ctrl_r.line_irq_vsize      <= {2'h0, ipcr_pkg::REG_RESET[ipcr_pkg::IDX_LIRQ_LO]};
      ctrl_r.pattern_en          <= 1'b0;
      ctrl_r.bar_style           <= 2'h0;
      ctrl_r.pattern_rolling     <= 1'b0;
      ctrl_r.pipe_test_sel       <= 1'b0;
      ctrl_r.same_random         <= 1'b0;
      ctrl_r.pattern_seed        <= 4'h0;
      ctrl_r.pattern_square_mono <= 1'b0;
      ctrl_r.pattern_transparent <= 1'b0;
      ctrl_r.pattern_sel         <= 2'h0;
    end
    else if (latch_pulse)
      ctrl_r <= live;
  end

  assign ctrl_o = ctrl_r;

  // Marks the cycle after a latch, when the new settings are in force.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      frame_latch_r <= 1'b0;
    else
      frame_latch_r <= latch_pulse;
  end

  assign frame_latch_o = frame_latch_r;

  // The processor debug byte is a scratch value, passed through at once.
  assign cpu_debug_o = reg_q[ipcr_pkg::IDX_CPU_DBG];

  // **************************************************************************
  // End-of-frame event.
  // **************************************************************************

  // The completion record restarts at each latch point.
  ipcr_eof_sel u_eof
  (
    .mclk_i        (mclk_i),
    .rst_n_i       (rst_n_i),
    .frame_start_i (latch_pulse),
    .done_i        (done_i),
    .sel_i         (eof_sel_o),
    .eof_o         (eof_o)
  );

  // **************************************************************************
  // Read path.
  // **************************************************************************

  // Address match over the map and the debug window; unmapped reads zero.
  always_comb
  begin
    rdata_nxt = 8'h00;
    hit_nxt   = 1'b0;
    for (int i = 0; i < int'(ipcr_pkg::REG_NUM); i++)
    begin
      if (reg_addr_i == ipcr_pkg::REG_ADDR[i])
      begin
        rdata_nxt = reg_q[i];
        hit_nxt   = 1'b1;
      end
    end
    for (int j = 0; j < int'(ipcr_pkg::DBG_NUM); j++)
    begin
      if (reg_addr_i == ipcr_pkg::DBG_BASE + 16'(j))
      begin
        rdata_nxt = isp_debug_i[8*j +: 8];
        hit_nxt   = 1'b1;
      end
    end
  end

  // Hit is combinational so the bus decoder can refuse unmapped addresses.
  assign reg_hit_o = hit_nxt;

  // Read data is captured on the read strobe and held until the next read.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_r <= 8'h00;
    else if (reg_rd_i)
      rdata_r <= rdata_nxt;
  end

  // One-cycle valid pulse one edge after the read strobe.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rvalid_r <= 1'b0;
    else
      rvalid_r <= reg_rd_i;
  end

  assign reg_rdata_o  = rdata_r;
  assign reg_rvalid_o = rvalid_r;

endmodule // ipcr_regs

/* File: design/ipcr_pkg.sv */
// ****************************************************************************
// Shared constants and types of the pipeline control register bank.
// ****************************************************************************
package ipcr_pkg;

  // **************************************************************************
  // Register map: one byte per address, twenty writable locations.
  // **************************************************************************
  localparam int unsigned REG_NUM = 20;

  localparam logic [15:0] REG_ADDR [0:REG_NUM-1] = '{
    16'h5000, 16'h5001, 16'h5002, 16'h5003, 16'h5004,
    16'h5005, 16'h5006, 16'h5007, 16'h5008, 16'h5009,
    16'h500a, 16'h500b, 16'h500c, 16'h500d, 16'h500e,
    16'h503b, 16'h503c, 16'h503d, 16'h503e, 16'h5044
  };

  // Reset value of each location, in map order.
  localparam logic [7:0] REG_RESET [0:REG_NUM-1] = '{
    8'hff, 8'hbf, 8'h7e, 8'h04, 8'h14,
    8'h08, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h02, 8'h00, 8'h00, 8'h00
  };

  // Bits that exist in each location; the others store nothing and read zero.
  localparam logic [7:0] REG_MASK [0:REG_NUM-1] = '{
    8'hff, 8'hff, 8'hff, 8'h1f, 8'h17,
    8'hff, 8'hff, 8'h07, 8'hff, 8'h03,
    8'hff, 8'h07, 8'hff, 8'h03, 8'hff,
    8'h03, 8'hff, 8'hb7, 8'hff, 8'hff
  };

  // Index of each location inside the map.
  localparam int unsigned IDX_EN_A     = 0;
  localparam int unsigned IDX_EN_B     = 1;
  localparam int unsigned IDX_EN_C     = 2;
  localparam int unsigned IDX_EVENT    = 3;
  localparam int unsigned IDX_WINDOW   = 4;
  localparam int unsigned IDX_SUBSAMP  = 5;
  localparam int unsigned IDX_FORMAT   = 6;
  localparam int unsigned IDX_PHOFF_HI = 7;
  localparam int unsigned IDX_PHOFF_LO = 8;
  localparam int unsigned IDX_PVOFF_HI = 9;
  localparam int unsigned IDX_PVOFF_LO = 10;
  localparam int unsigned IDX_FHOFF_HI = 11;
  localparam int unsigned IDX_FHOFF_LO = 12;
  localparam int unsigned IDX_FVOFF_HI = 13;
  localparam int unsigned IDX_FVOFF_LO = 14;
  localparam int unsigned IDX_LIRQ_HI  = 15;
  localparam int unsigned IDX_LIRQ_LO  = 16;
  localparam int unsigned IDX_PAT_A    = 17;
  localparam int unsigned IDX_PAT_B    = 18;
  localparam int unsigned IDX_CPU_DBG  = 19;

  // Read-only debug window.
  localparam logic [15:0] DBG_BASE = 16'h5040;
  localparam int unsigned DBG_NUM  = 4;

  // End-of-frame source codes.
  localparam logic [2:0] EOF_EXPOSURE = 3'h0;
  localparam logic [2:0] EOF_AWB      = 3'h1;
  localparam logic [2:0] EOF_TONE     = 3'h2;
  localparam logic [2:0] EOF_COMBINE  = 3'h3;
  localparam logic [2:0] EOF_ALL      = 3'h4;

  // **************************************************************************
  // Decoded controls handed to the pipeline.
  // **************************************************************************
  typedef struct packed {
    logic [7:0]  stage_en_a;
    logic [7:0]  stage_en_b;
    logic [7:0]  stage_en_c;
    logic        chroma_reduce_drop;
    logic        auto_window;
    logic [2:0]  dummy_lines;
    logic        vsub_en;
    logic        lenc_centre_auto;
    logic        drop_row_second;
    logic        drop_col_second;
    logic        sub_average;
    logic        luma_drop;
    logic        chroma_drop;
    logic        sub_en;
    logic [1:0]  raw_mode_man;
    logic [1:0]  yuv_mode_man;
    logic        raw_mode_man_en;
    logic        yuv_mode_man_en;
    logic        yuv_en_man;
    logic        yuv_en_man_en;
    logic [10:0] pipe_hoff;
    logic [9:0]  pipe_voff;
    logic [10:0] fuse_hoff;
    logic [9:0]  fuse_voff;
    logic [9:0]  line_irq_vsize;
    logic        pattern_en;
    logic [1:0]  bar_style;
    logic        pattern_rolling;
    logic        pipe_test_sel;
    logic        same_random;
    logic [3:0]  pattern_seed;
    logic        pattern_square_mono;
    logic        pattern_transparent;
    logic [1:0]  pattern_sel;
  } ipcr_ctrl_type;

  // Stage completion events, one pulse each.
  typedef struct packed {
    logic combine;
    logic tone;
    logic awb;
    logic exposure_loop_finished;
  } ipcr_done_type;

endpackage

/* File: design/ipcr_byte_reg.sv */
`timescale 1ns/10ps
// ****************************************************************************
// One byte of the bank with its own reset value and implemented-bit mask.
// ****************************************************************************
module ipcr_byte_reg
#(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] MASK    = 8'hff
)
(
  // Clock and reset.
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // Write port.
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  // Stored value.
  output logic      [7:0] q_o
);

  // Unused bits are forced low so they neither store nor read back.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q_o <= RST_VAL & MASK;
    else if (wr_i)
      q_o <= wdata_i & MASK;
  end

endmodule // ipcr_byte_reg

/* File: design/ipcr_eof_sel.sv */
`timescale 1ns/10ps
// ****************************************************************************
// End-of-frame event selection among the stage completion events.
// ****************************************************************************
module ipcr_eof_sel
(
  // Clock and reset.
  input  wire logic                   mclk_i,
  input  wire logic                   rst_n_i,
  // Frame boundary and events.
  input  wire logic                   frame_start_i,
  input  wire ipcr_pkg::ipcr_done_type done_i,
  input  wire logic [2:0]             sel_i,
  // Selected event.
  output logic                        eof_o
);

  logic [3:0] seen_r;
  logic [3:0] seen_nxt;
  logic       fired_r;
  logic       all_now;
  logic       eof_nxt;

  // A completion in the same cycle as the frame start is kept: set wins.
  assign seen_nxt = (seen_r & {4{~frame_start_i}}) | done_i;
  assign all_now  = &(seen_r | done_i);

  // Pick the event; unlisted codes select nothing.
  always_comb
  begin
    eof_nxt = 1'b0;
    case (sel_i)
      ipcr_pkg::EOF_EXPOSURE: eof_nxt = done_i.exposure_loop_finished;
      ipcr_pkg::EOF_AWB:      eof_nxt = done_i.awb;
      ipcr_pkg::EOF_TONE:     eof_nxt = done_i.tone;
      ipcr_pkg::EOF_COMBINE:  eof_nxt = done_i.combine;
      ipcr_pkg::EOF_ALL:      eof_nxt = all_now & ~fired_r;
      default:                eof_nxt = 1'b0;
    endcase
  end

  // Sticky completion record and one-shot guard for the combined event.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      seen_r  <= 4'h0;
      fired_r <= 1'b0;
    end
    else
    begin
      seen_r  <= seen_nxt;
      fired_r <= (fired_r & ~frame_start_i) | (all_now & ~frame_start_i);
    end
  end

  // Registered event pulse.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      eof_o <= 1'b0;
    else
      eof_o <= eof_nxt;
  end

endmodule // ipcr_eof_sel

/* File: testbench/ipcr_regs_properties.sv */
`timescale 1ns/10ps
// ****************************************************************************
// Port properties of the register bank.
// ****************************************************************************
module ipcr_regs_checker
(
  // Watched ports, grouped by width.
  input logic        mclk_i, rst_n_i, reg_wr_i, reg_rd_i, pre_sof_i, vsync_i,
  input logic        reg_rvalid_o, reg_hit_o, latch_on_vsync_o, eof_o, frame_latch_o,
  input logic [15:0] reg_addr_i,
  input logic [7:0]  reg_wdata_i, reg_rdata_o, cpu_debug_o,
  input logic [31:0] isp_debug_i,
  input logic [2:0]  eof_sel_o,
  input ipcr_pkg::ipcr_done_type done_i,
  input ipcr_pkg::ipcr_ctrl_type ctrl_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // A single-source selection whose event is present at this edge.
  wire sel_hit = !eof_sel_o[2] && done_i[eof_sel_o[1:0]];
  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered next cycle");
  a_rdata_hold: assert property (!reg_rvalid_o |-> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  a_debug_read: assert property (reg_rd_i && reg_addr_i == 16'h5042 |=>
    reg_rdata_o == $past(isp_debug_i[23:16])) else $error("debug byte wrong");
  a_debug_hit: assert property (reg_addr_i[15:2] == 14'h1410 |-> reg_hit_o)
    else $error("debug window not mapped");
  a_gap_miss: assert property (reg_addr_i == 16'h500f |-> !reg_hit_o)
    else $error("hole reported as mapped");
  a_cpu_debug: assert property (reg_wr_i && reg_addr_i == 16'h5044 |=>
    cpu_debug_o == $past(reg_wdata_i)) else $error("processor byte wrong");
  a_event_reg: assert property (reg_wr_i && reg_addr_i == 16'h5003 |=>
    {latch_on_vsync_o, eof_sel_o} == $past(reg_wdata_i[3:0])) else $error("event bits");
  a_presof_latch: assert property (pre_sof_i && !latch_on_vsync_o |=> frame_latch_o)
    else $error("pre-start latch missed");
  a_vsync_latch: assert property (latch_on_vsync_o && $rose(vsync_i) |=> frame_latch_o)
    else $error("sync latch missed");
  a_no_latch: assert property (!pre_sof_i && !vsync_i |=> !frame_latch_o)
    else $error("latch without cause");
  a_ctrl_hold: assert property (!frame_latch_o |-> $stable(ctrl_o))
    else $error("controls moved between latches");
  a_eof_single: assert property (sel_hit |=> eof_o)
    else $error("selected event lost");
  a_eof_legal: assert property (eof_o |-> $past(eof_sel_o) <= 3'h4)
    else $error("event from illegal select");
endmodule // ipcr_regs_checker

bind ipcr_regs ipcr_regs_checker i_chk (.mclk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .pre_sof_i,
  .vsync_i, .reg_rvalid_o, .reg_hit_o, .latch_on_vsync_o, .eof_o, .frame_latch_o, .reg_addr_i,
  .reg_wdata_i, .reg_rdata_o, .cpu_debug_o, .isp_debug_i, .eof_sel_o, .done_i, .ctrl_o);

/* File: testbench/ipcr_host_model.sv */
`timescale 1ns/10ps
// ****************************************************************************
// Host side of the byte access port.
// ****************************************************************************
module ipcr_host_model
(
  // Clock.
  input  logic        mclk_i,
  // Access port towards the bank.
  output logic [15:0] reg_addr_o,
  output logic        reg_wr_o,
  output logic        reg_rd_o,
  output logic [7:0]  reg_wdata_o,
  input  logic [7:0]  reg_rdata_i,
  input  logic        reg_rvalid_i
);
  // Idle bus at time zero.
  initial
  begin
    reg_addr_o  = 16'hffff;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // Released lines turn over, so a stale value can never pass for a fresh one.
  task automatic write_byte(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(negedge mclk_i);
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~a;
    reg_wdata_o = ~d;
  endtask
  // The answer is registered at the taking edge and read at the negedge half a cycle later.
  task automatic read_byte(input logic [15:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(negedge mclk_i);
    d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hxx;
    reg_rd_o   = 1'b0;
    reg_addr_o = ~a;
  endtask
endmodule // ipcr_host_model

/* File: testbench/ipcr_regs_tb_top.sv */
`timescale 1ns/10ps
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin mismatches++; \
  $display("[FAIL] %0t ns got %h expected %h", $time, act, exp); end end
// ****************************************************************************
// Self-checking bench of the register bank.
// ****************************************************************************
module ipcr_regs_tb_top;
  logic        mclk_i, rst_n_i, pre_sof_i, vsync_i, reg_wr_i, reg_rd_i;
  logic        reg_rvalid_o, reg_hit_o, latch_on_vsync_o, eof_o, frame_latch_o;
  logic [15:0] reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o, cpu_debug_o, rd;
  logic [31:0] isp_debug_i;
  logic [2:0]  eof_sel_o;
  int          mismatches, check_count;
  ipcr_pkg::ipcr_done_type done_i;
  ipcr_pkg::ipcr_ctrl_type ctrl_o;
  // Clock of 25 ns period.
  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  ipcr_host_model i_host (.mclk_i, .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o),
    .reg_rvalid_i(reg_rvalid_o));
  ipcr_regs i_dut (.mclk_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .reg_rvalid_o, .reg_hit_o, .pre_sof_i, .vsync_i, .done_i, .isp_debug_i,
    .ctrl_o, .latch_on_vsync_o, .eof_sel_o, .eof_o, .frame_latch_o, .cpu_debug_o);
  // Reads one byte and compares it.
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    i_host.read_byte(a, rd);
    `CHK(rd, e)
  endtask
  // Drives pre-start and done for one cycle, leaving vsync held; the answering edge has landed on return.
  task automatic step(input logic ps, input logic vs, input logic [3:0] dn);
    @(negedge mclk_i);
    pre_sof_i = ps;
    vsync_i   = vs;
    done_i    = ipcr_pkg::ipcr_done_type'(dn);
    @(negedge mclk_i);
    pre_sof_i = 1'b0;
    done_i    = '0;
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // The sequence needs about two hundred cycles; this bound only catches a hang.
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    mismatches++;
    summarize();
  end
  // Main sequence.
  initial
  begin
    rst_n_i = 1'b0;
    pre_sof_i = 1'b0;
    vsync_i = 1'b0;
    done_i = '0;
    isp_debug_i = 32'h44332211;
    repeat (10) @(negedge mclk_i);
    rst_n_i = 1'b1;
    for (int i = 0; i < ipcr_pkg::REG_NUM; i++)
      rd_chk(ipcr_pkg::REG_ADDR[i], ipcr_pkg::REG_RESET[i]);
    for (int j = 0; j < 4; j++)
      rd_chk(16'h5040 + 16'(j), isp_debug_i[8*j +: 8]);
    i_host.write_byte(16'h5040, 8'h5a);
    rd_chk(16'h5040, 8'h11);
    rd_chk(16'h500f, 8'h00);
    // Writes stay hidden until the next frame latch.
    i_host.write_byte(16'h5005, 8'h5a);
    i_host.write_byte(16'h5007, 8'hff);
    i_host.write_byte(16'h5008, 8'h34);
    i_host.write_byte(16'h503d, 8'hff);
    step(1'b0, 1'b0, 4'h0);
    `CHK(ctrl_o.pipe_hoff, 11'h000)
    step(1'b1, 1'b0, 4'h0);
    `CHK(frame_latch_o, 1'b1)
    `CHK({ctrl_o.vsub_en, ctrl_o.lenc_centre_auto, ctrl_o.sub_average, ctrl_o.sub_en}, 4'h6)
    `CHK(ctrl_o.pipe_hoff, 11'h734)
    `CHK({ctrl_o.pattern_en, ctrl_o.bar_style, ctrl_o.same_random}, 4'hf)
    // Latch moved to the vertical sync edge.
    i_host.write_byte(16'h5003, 8'h08);
    i_host.write_byte(16'h5005, 8'ha5);
    step(1'b1, 1'b0, 4'h0);
    `CHK(ctrl_o.sub_en, 1'b0)
    step(1'b0, 1'b1, 4'h0);
    `CHK({ctrl_o.vsub_en, ctrl_o.sub_average, ctrl_o.sub_en}, 3'h5)
    vsync_i = 1'b0;
    // Each single source ignores the other three events.
    for (int s = 0; s < 4; s++)
    begin
      i_host.write_byte(16'h5003, 8'(s));
      step(1'b0, 1'b0, 4'hf ^ (4'h1 << s));
      `CHK(eof_o, 1'b0)
      step(1'b0, 1'b0, 4'h1 << s);
      `CHK(eof_o, 1'b1)
    end
    // Combined source fires once, after the last of the four.
    i_host.write_byte(16'h5003, 8'h04);
    step(1'b1, 1'b0, 4'h0);
    for (int k = 0; k < 4; k++)
    begin
      step(1'b0, 1'b0, 4'h1 << k);
      `CHK(eof_o, k == 3)
    end
    step(1'b0, 1'b0, 4'hf);
    `CHK(eof_o, 1'b0)
    i_host.write_byte(16'h5003, 8'h05);
    step(1'b0, 1'b0, 4'hf);
    `CHK(eof_o, 1'b0)
    // Unused bits neither store nor read back.
    for (int i = 0; i < ipcr_pkg::REG_NUM; i++)
    begin
      i_host.write_byte(ipcr_pkg::REG_ADDR[i], 8'hff);
      rd_chk(ipcr_pkg::REG_ADDR[i], ipcr_pkg::REG_MASK[i]);
    end
    // With every bit set and a latch, each decoded field must read all ones.
    step(1'b0, 1'b1, 4'h0);
    `CHK(&ctrl_o, 1'b1)
    vsync_i = 1'b0;
    `CHK(cpu_debug_o, 8'hff)
    rst_n_i = 1'b0;
    @(negedge mclk_i);
    rst_n_i = 1'b1;
    rd_chk(16'h5001, 8'hbf);
    summarize();
  end
endmodule // ipcr_regs_tb_top
